// ### pkg/dio_consts.svh
// Register offsets, field positions and reset values of the digital I/O card
// Operation
// [RULE1] Each group owns an 8-bit direction control register
// [RULE2] Reset leaves every line an undriven input
// [RULE3] Software writes each control register at initialisation
// [RULE4] Software sets bit seven when configuring directions
// [RULE5] Control readback forces bits 2,5,6,7 zero
// [RULE6] Latch writes held while input, driven later
// [RULE7] Unwritten latch loads sampled pins on output
// [RULE8] Bit0 C low, 1 B, 3 C high, 4 A; one=input
// [RULE9] All interrupt sources disabled after reset
// [RULE10] Write zero enables change-of-state; read shows enables
// [RULE11] Enable bits 0-5 ports, 6-7 edge enables
// [RULE12] Enabled port line change sets status, requests interrupt
// [RULE13] Enable register access arms rising-edge bit-three interrupt
// [RULE14] Jumper input per group gates edge interrupt
// [RULE15] Enable bits read one enabled, zero disabled
// [RULE16] Status reads one where change seen since clear
// [RULE17] Status bits 0-5 ports, 6-7 group edge
// [RULE18] Any status write clears bits and request
// [RULE19] Control registers at offsets three and seven
// [RULE20] Data at 0-2 and 4-6; read pins, write latch
// [RULE21] Port C nibbles have independent directions
// [RULE22] Lines pass two-stage synchroniser before detection
// [RULE23] Request is a level while any status set
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH
`define OFF_PORT_A 4'h0
`define OFF_PORT_B 4'h1
`define OFF_PORT_C 4'h2
`define OFF_CTRL0 4'h3
`define OFF_CTRL1 4'h7
`define OFF_IRQ_ENABLE 4'hb
`define OFF_IRQ_STATUS 4'hf
`define GROUP_STRIDE 4'h4
`define CTRL_C_LO 0
`define CTRL_B 1
`define CTRL_C_HI 3
`define CTRL_A 4
`define CTRL_SET_FLAG 7
`define CTRL_READ_MASK 8'h1b
`define CTRL_RESET 8'h1b
`define COS_MASK_RESET 6'h3f
`define EDGE_BIT 3
`define STATUS_EDGE0 6
`define STATUS_EDGE1 7
`endif

// ### pkg/dio_pkg.sv
// Types shared by the digital I/O card logic
package dio_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] offset_t;
endpackage : dio_pkg

// ### design/dio_port_group.sv
// One I/O group: three ports with direction control, latches and change detection
`timescale 1ns/100ps
`include "dio_consts.svh"
module dio_port_group (
    input wire logic clk,
    input wire logic rst,
    input wire logic [23:0] pins_in,
    input wire logic [3:0] sel,
    input wire logic wr,
    input wire dio_pkg::byte_t wdata,
    output logic [23:0] pins_out,
    output logic [23:0] pins_oe,
    output dio_pkg::byte_t ctrl_rd,
    output logic [23:0] samp,
    output logic [2:0] changed,
    output logic bit3_rise
);
    import dio_pkg::*;

    logic [23:0] sync1;
    logic [23:0] sync2;
    logic [23:0] sync_prev;
    logic [23:0] latch;
    logic [2:0] written;
    logic [4:0] dir_in;   // A, C high, -, B, C low in control-bit order
    logic [23:0] is_in;
    logic [2:0] fill;     // Marks the samples that hold real pin data

    // *****************************
    // Synchroniser and detection
    // *****************************
    // Two-stage synchroniser; only stage two feeds detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 24'h000000;
            sync2 <= 24'h000000;
            sync_prev <= 24'h000000;
            fill <= 3'h0;
        end else begin
            sync1 <= pins_in;     // [RULE22]
            sync2 <= sync1;
            sync_prev <= sync2;
            fill <= {fill[1:0], 1'b1};
        end
    end

    assign samp = sync2;
    // Per-port change flags, compared sample to sample; held off until both
    // samples are real pin data, so a line idling high gives no edge after reset
    assign changed[0] = fill[2] && (|(sync2[7:0] ^ sync_prev[7:0]));    // [RULE22]
    assign changed[1] = fill[2] && (|(sync2[15:8] ^ sync_prev[15:8]));
    assign changed[2] = fill[2] && (|(sync2[23:16] ^ sync_prev[23:16]));
    assign bit3_rise = fill[2] && sync2[16 + `EDGE_BIT] && !sync_prev[16 + `EDGE_BIT];

    // *****************************
    // Direction control
    // *****************************
    // Direction bits, all inputs after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_in <= 5'h1f;  // [RULE2]
        end else if (wr && sel == `OFF_CTRL0 && wdata[`CTRL_SET_FLAG]) begin
            dir_in <= wdata[4:0];  // [RULE1] [RULE8]
        end
    end

    assign ctrl_rd = {3'h0, dir_in} & `CTRL_READ_MASK;  // [RULE5]
    // Nibble-split port C, whole ports A and B
    assign is_in = {{4{dir_in[`CTRL_C_HI]}}, {4{dir_in[`CTRL_C_LO]}},
                    {8{dir_in[`CTRL_B]}}, {8{dir_in[`CTRL_A]}}};  // [RULE21]

    // *****************************
    // Output latches
    // *****************************
    // Unwritten latch bits track pins while input and hold once output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch <= 24'h000000;
            written <= 3'h0;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (wr && sel == 4'(p)) begin
                    latch[p*8 +: 8] <= wdata;  // [RULE6]
                    written[p] <= 1'b1;
                end else if (!written[p]) begin
                    latch[p*8 +: 8] <= (sync2[p*8 +: 8] & is_in[p*8 +: 8])
                                       | (latch[p*8 +: 8] & ~is_in[p*8 +: 8]);  // [RULE7]
                end
            end
        end
    end

    // Only outputs drive; undriven while input
    assign pins_oe = ~is_in;     // [RULE2]
    assign pins_out = latch & ~is_in;  // [RULE6]
endmodule : dio_port_group

// ### design/dio_direction_and_cos_irq.sv
// Register file and interrupt logic of the 48-line digital I/O card
`timescale 1ns/100ps
`include "dio_consts.svh"
module dio_direction_and_cos_irq (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire dio_pkg::offset_t ADDR_IN,
    input wire logic RD_IN,
    input wire logic WR_IN,
    input wire dio_pkg::byte_t WDATA_IN,
    output dio_pkg::byte_t RDATA_OUT,
    input wire logic [47:0] DIGITAL_IO_IN,
    output logic [47:0] DIGITAL_IO_OUT,
    output logic [47:0] DIGITAL_IO_OE_OUT,
    input wire logic GROUP0_EDGE_IRQ_JUMPER_IN,
    input wire logic GROUP1_EDGE_IRQ_JUMPER_IN,
    output logic IRQ_OUT
);
    import dio_pkg::*;

    logic [3:0] sel [2];
    logic [1:0] grp_wr;
    byte_t ctrl_rd [2];
    logic [23:0] samp [2];
    logic [2:0] changed [2];
    logic [1:0] rise;
    logic [5:0] cos_mask;
    logic edge_armed;
    logic [1:0] edge_en;
    byte_t enable_view;
    byte_t status;
    byte_t events;
    byte_t next_rdata;
    logic status_wr;

    // *****************************
    // Groups
    // *****************************
    // Local offset inside each group of four addresses
    assign sel[0] = ADDR_IN;
    assign sel[1] = ADDR_IN - `GROUP_STRIDE;
    assign grp_wr[0] = WR_IN && ADDR_IN < `GROUP_STRIDE;            // [RULE19] [RULE20]
    assign grp_wr[1] = WR_IN && ADDR_IN >= `GROUP_STRIDE && ADDR_IN <= `OFF_CTRL1;

    for (genvar g = 0; g < 2; g++) begin : groups
        dio_port_group u_grp (
            .clk(CORE_CLK_IN),
            .rst(RESET_IN),
            .pins_in(DIGITAL_IO_IN[g*24 +: 24]),
            .sel(sel[g]),
            .wr(grp_wr[g]),
            .wdata(WDATA_IN),
            .pins_out(DIGITAL_IO_OUT[g*24 +: 24]),
            .pins_oe(DIGITAL_IO_OE_OUT[g*24 +: 24]),
            .ctrl_rd(ctrl_rd[g]),
            .samp(samp[g]),
            .changed(changed[g]),
            .bit3_rise(rise[g])
        );
    end

    // *****************************
    // Interrupt enables
    // *****************************
    // Change-of-state mask: one disables, all masked at reset
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            cos_mask <= `COS_MASK_RESET;  // [RULE9]
        end else if (WR_IN && ADDR_IN == `OFF_IRQ_ENABLE) begin
            cos_mask <= WDATA_IN[5:0];    // [RULE10]
        end
    end

    // Any access to the enable register arms the edge interrupt
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            edge_armed <= 1'b0;  // [RULE9]
        end else if ((RD_IN || WR_IN) && ADDR_IN == `OFF_IRQ_ENABLE) begin
            edge_armed <= 1'b1;  // [RULE13]
        end
    end

    assign edge_en = {GROUP1_EDGE_IRQ_JUMPER_IN, GROUP0_EDGE_IRQ_JUMPER_IN}
                     & {2{edge_armed}};  // [RULE14]
    assign enable_view = {edge_en, ~cos_mask};  // [RULE11] [RULE15]

    // *****************************
    // Status and request
    // *****************************
    assign events = {rise & edge_en,
                     changed[1] & ~cos_mask[5:3],
                     changed[0] & ~cos_mask[2:0]};  // [RULE12] [RULE13] [RULE17]
    assign status_wr = WR_IN && ADDR_IN == `OFF_IRQ_STATUS;

    // Sticky status; a same-cycle event survives the clear
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            status <= 8'h00;
        end else if (status_wr) begin
            status <= events;  // [RULE18]
        end else begin
            status <= status | events;  // [RULE16]
        end
    end

    assign IRQ_OUT = |status;  // [RULE23]

    // *****************************
    // Read path
    // *****************************
    // Read mux, registered; unmapped offsets read zero
    always_comb begin
        if (ADDR_IN == `OFF_CTRL0) begin
            next_rdata = ctrl_rd[0];  // [RULE5]
        end else if (ADDR_IN == `OFF_CTRL1) begin
            next_rdata = ctrl_rd[1];
        end else if (ADDR_IN < `OFF_CTRL0) begin
            next_rdata = samp[0][ADDR_IN[1:0]*8 +: 8];  // [RULE20]
        end else if (ADDR_IN < `OFF_CTRL1) begin
            next_rdata = samp[1][ADDR_IN[1:0]*8 +: 8];
        end else if (ADDR_IN == `OFF_IRQ_ENABLE) begin
            next_rdata = enable_view;  // [RULE15]
        end else if (ADDR_IN == `OFF_IRQ_STATUS) begin
            next_rdata = status;  // [RULE16]
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            RDATA_OUT <= 8'h00;
        end else if (RD_IN) begin
            RDATA_OUT <= next_rdata;
        end
    end
endmodule : dio_direction_and_cos_irq

// ### bench/dio_field_model.sv
// Field equipment model on the card's port lines
`timescale 1ns/100ps
module dio_field_model (
    input wire logic [47:0] drive_in,
    input wire logic [47:0] out_in,
    input wire logic [47:0] oe_in,
    output logic [47:0] pins_out
);
    // Card level where it drives, field level where the line is an input
    assign pins_out = (out_in & oe_in) | (drive_in & ~oe_in);
endmodule : dio_field_model

// ### bench/dio_direction_and_cos_irq_sva.sv
// Assertion checker for the digital I/O register block
`timescale 1ns/100ps
module dio_chk (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire dio_pkg::offset_t ADDR_IN,
    input wire logic RD_IN,
    input wire logic WR_IN,
    input wire dio_pkg::byte_t WDATA_IN,
    input wire dio_pkg::byte_t RDATA_OUT,
    input wire logic [47:0] DIGITAL_IO_OUT,
    input wire logic [47:0] DIGITAL_IO_OE_OUT,
    input wire logic IRQ_OUT
);
    import dio_pkg::*;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // ************
    // Properties
    // ************
    ctrl_read_a: assert property (
        RD_IN && (ADDR_IN == 4'h3 || ADDR_IN == 4'h7) |=>
        RDATA_OUT[7:5] == 3'h0 && !RDATA_OUT[2]) else $error("control readback bits");
    unmapped_read_a: assert property (
        RD_IN && ADDR_IN inside {4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he} |=>
        RDATA_OUT == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!RD_IN |=> $stable(RDATA_OUT))
        else $error("read data moved without read");
    irq_fall_a: assert property (
        $fell(IRQ_OUT) |-> $past(WR_IN) && $past(ADDR_IN) == 4'hf)
        else $error("request dropped without clear");
    oe_change_a: assert property ($changed(DIGITAL_IO_OE_OUT) |-> $past(WR_IN) &&
        $past(WDATA_IN) >= 8'h80 && ($past(ADDR_IN) == 4'h3 || $past(ADDR_IN) == 4'h7))
        else $error("direction moved without set write");
    out_masked_a: assert property (
        (DIGITAL_IO_OUT & ~DIGITAL_IO_OE_OUT) == 48'h0) else $error("drive on an input line");
    group0_oe_a: assert property (DIGITAL_IO_OE_OUT[7:0] inside {8'h00, 8'hff} &&
        DIGITAL_IO_OE_OUT[15:8] inside {8'h00, 8'hff}) else $error("group0 split");
    nibble_oe_a: assert property (DIGITAL_IO_OE_OUT[43:40] inside {4'h0, 4'hf} &&
        DIGITAL_IO_OE_OUT[47:44] inside {4'h0, 4'hf}) else $error("nibble split");
    irq_cov: cover property ($rose(IRQ_OUT));
    dir_cov: cover property ($changed(DIGITAL_IO_OE_OUT));
    clear_cov: cover property (WR_IN && ADDR_IN == 4'hf && IRQ_OUT);
endmodule : dio_chk
bind dio_direction_and_cos_irq dio_chk u_chk (.CORE_CLK_IN, .RESET_IN, .ADDR_IN, .RD_IN,
    .WR_IN, .WDATA_IN, .RDATA_OUT, .DIGITAL_IO_OUT, .DIGITAL_IO_OE_OUT, .IRQ_OUT);

// ### bench/tb.sv
// Self-checking testbench of the digital I/O register block
`timescale 1ns/100ps
module tb;
    import dio_pkg::*;
    logic clk, rst, rd, wr, j0, j1, irq;
    offset_t addr;
    byte_t wdata, rdata;
    logic [47:0] pins, dout, doe, drive;
    integer seed, fail_count, total_checks, i;
    byte_t ectl [2];
    byte_t emask, estat;
    logic earmed;
    dio_direction_and_cos_irq uut (.CORE_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr),
        .RD_IN(rd), .WR_IN(wr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .DIGITAL_IO_IN(pins),
        .DIGITAL_IO_OUT(dout), .DIGITAL_IO_OE_OUT(doe), .GROUP0_EDGE_IRQ_JUMPER_IN(j0),
        .GROUP1_EDGE_IRQ_JUMPER_IN(j1), .IRQ_OUT(irq));
    dio_field_model field (.drive_in(drive), .out_in(dout), .oe_in(doe), .pins_out(pins));
    // ************
    // Tasks
    // ************
    task chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One access, one idle cycle after it; the register model follows the rules
    task acc(input logic w, input offset_t a, input byte_t d);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        if (a == 4'hb) begin
            earmed = 1'b1;
        end
        if (w && (a == 4'h3 || a == 4'h7) && d[7]) begin
            ectl[a[2]] = d & 8'h1b;
        end
        if (w && a == 4'hb) begin
            emask = d & 8'h3f;
        end
        if (w && a == 4'hf) begin
            estat = 8'h00;
        end
        wr = 0;
        rd = 0;
        @(negedge clk);
    endtask : acc
    // Expected enable view: edge enables on top, inverted change mask below
    function automatic byte_t env();
        return {earmed & j1, earmed & j0, ~emask[5:0]};
    endfunction : env
    task rdc(input offset_t a, input byte_t e);
        acc(0, a, 8'h00);
        chk(rdata, e);
    endtask : rdc
    task wt;
        repeat (5) @(negedge clk);
    endtask : wt
    task finish_test;
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    // Clock at 50 MHz
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // Main sequence
    initial begin
        seed = 37835;
        {rst, rd, wr, addr, wdata, j0, j1} = {3'h4, 4'h0, 8'h00, 2'h3};
        fail_count = 0;
        total_checks = 0;
        ectl[0] = 8'h1b;
        ectl[1] = 8'h1b;
        emask = 8'h3f;
        estat = 8'h00;
        earmed = 1'b0;
        drive = 48'({$random(seed), $random(seed)});
        repeat (5) @(negedge clk);
        rst = 0;
        @(negedge clk);
        chk(doe, 48'h0);
        rdc(4'h3, ectl[0]);
        rdc(4'h7, ectl[1]);
        rdc(4'hb, env());
        rdc(4'hf, estat);
        acc(1, 4'h3, 8'h9b);
        acc(1, 4'h7, 8'h9b);
        chk(doe, 48'h0);
        for (i = 8; i < 15; i++) if (i != 11) begin
            acc(1, 4'(i), 8'($random(seed)));
            rdc(4'(i), 8'h00);
        end
        acc(1, 4'h3, 8'h00);
        rdc(4'h3, ectl[0]);
        acc(1, 4'h3, 8'h8b);
        chk(doe[23:0], 24'h0000ff);
        chk(dout[7:0], drive[7:0]);
        acc(1, 4'h1, 8'h3c);
        chk(doe[15:8], 8'h00);
        acc(1, 4'h3, 8'h89);
        chk(dout[15:8], 8'h3c);
        rdc(4'h3, ectl[0]);
        wt;
        chk(dout[7:0], drive[7:0]);
        rdc(4'h1, 8'h3c);
        rdc(4'h0, drive[7:0]);
        acc(1, 4'h7, 8'h93);
        chk(doe[47:24], 24'hf00000);
        chk(dout[47:44], drive[47:44]);
        rdc(4'h7, ectl[1]);
        acc(1, 4'hb, 8'hf7);
        rdc(4'hb, env());
        drive[24] = ~drive[24];
        estat[3] = 1'b1;
        wt;
        chk(irq, 1'b1);
        rdc(4'hf, estat);
        acc(1, 4'hf, 8'($random(seed)));
        chk(irq, 1'b0);
        rdc(4'hf, estat);
        drive[32] = ~drive[32];
        drive[19] = 0;
        wt;
        chk(irq, 1'b0);
        drive[19] = 1;
        estat[6] = 1'b1;
        wt;
        rdc(4'hf, estat);
        acc(1, 4'hf, 8'h00);
        j1 = 0;
        drive[43] = 0;
        wt;
        drive[43] = 1;
        wt;
        chk(irq, 1'b0);
        rdc(4'hb, env());
        rst = 1;
        @(negedge clk);
        rst = 0;
        ectl[0] = 8'h1b;
        ectl[1] = 8'h1b;
        emask = 8'h3f;
        estat = 8'h00;
        earmed = 1'b0;
        rdc(4'hb, env());
        rdc(4'h3, ectl[0]);
        wt;
        rdc(4'hf, estat);
        chk(doe, 48'h0);
        finish_test;
    end
endmodule : tb
